// ===== verilog/pad_bias_cfg.svh
/*
 Constants of the pad bias, reference and always-on regulator registers:
 word indexes, field positions, reset values and write masks.
 Assumes the includer uses the byte address four times the word index.
*/
// Function
// - Bit 6 enables control bus pull-ups
// - Bit 5 enables scaling bus pull-ups
// - Bit 4 power request pull-up, resets on
// - Bits 3..0 enable four pad pull-downs
// - Reference state read-only, reset 01
// - Regulator state read-only, 01 active, 11 sleep
// - Mask set keeps regulator full-load when off
// - Mask clear puts regulator low-power when off
// - Backup state always forces regulator low-power
`ifndef PAD_BIAS_CFG_SVH
`define PAD_BIAS_CFG_SVH

// Word indexes; byte address is the index times four
`define PAD_BIAS_IDX 6'h1C
`define REF_STATE_IDX 6'h1D
`define AON_REG_IDX 6'h1E

// Pad bias field positions
`define PB_CTRL_BUS_BIT 6
`define PB_SCALING_BUS_BIT 5
`define PB_POWER_REQ_BIT 4
`define PB_SLEEP_BIT 3
`define PB_HOLD_BIT 2
`define PB_COLD_RESET_BIT 1
`define PB_SECOND_RESET_BIT 0
`define PB_RESET 7'h1F
`define PB_WRITE_MASK 8'h7F

// Regulator register fields
`define AON_MASK_BIT 3
`define AON_MASK_RESET 1'h0
`define AON_WRITE_MASK 8'h08

// State field position and reset code for both state fields
`define STATE_LSB 0
`define STATE_RESET 2'h1

`endif

// ===== verilog/pad_bias_pkg.sv
/*
 Types shared by the pad bias register bank: power modes, state codes,
 register selects and the packed carriers for bus request and pad bias.
 Assumes the constants header is compiled alongside.
*/
package pad_bias_pkg;

   // Device power mode as reported by the power controller
   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_OFF = 2'b10,
      MODE_BACKUP = 2'b11
   } power_mode_t;

   // Two-bit state field codes
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_RESERVED = 2'b10,
      ST_SLEEP = 2'b11
   } supply_state_t;

   // Which register a bus access hits
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_PAD = 2'b01,
      SEL_REF = 2'b10,
      SEL_AON = 2'b11
   } reg_sel_t;

   // Bus slave handshake states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01,
      BUS_GAP = 2'b10
   } bus_state_t;

   // Classic Wishbone request as one carrier
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   // Pad bias enables, bit order as in the register
   typedef struct packed {
      logic ctrl_bus_pullup_en;
      logic scaling_bus_pullup_en;
      logic power_request_pullup_en;
      logic sleep_pin_pulldown_en;
      logic hold_pin_pulldown_en;
      logic cold_reset_pin_pulldown_en;
      logic second_reset_out_pulldown_en;
   } pad_bias_t;

endpackage : pad_bias_pkg

// ===== verilog/wb_word_slave.sv
/*
 Classic Wishbone handshake for a single-word register slave.
 Assumes a master that holds its request until it samples ack.
*/
`timescale 1ns/10ps
`default_nettype none
module wb_word_slave
   import pad_bias_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire pad_bias_pkg::wb_req_t req,
   output logic take,
   output logic commit,
   output logic ack
);
   import pad_bias_pkg::*;

   bus_state_t state_r;
   bus_state_t state_nxt;

   // Take in idle, ack one cycle, then one gap so ack never doubles
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BUS_IDLE: begin
            if (req.cyc && req.stb) begin
               state_nxt = BUS_ACK;
            end
         end
         BUS_ACK: state_nxt = BUS_GAP;
         BUS_GAP: state_nxt = BUS_IDLE;
         default: state_nxt = BUS_IDLE;
      endcase
   end

   // Handshake state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= BUS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign take = (state_r == BUS_IDLE) && req.cyc && req.stb;
   assign ack = (state_r == BUS_ACK);
   // Writes land on the edge at which the master samples ack
   assign commit = ack && req.we;

endmodule : wb_word_slave
`default_nettype wire

// ===== verilog/supply_state_tracker.sv
/*
 Holds one read-only two-bit supply state field and follows the power
 mode. Assumes the mode comes from logic on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pad_bias_cfg.svh"
module supply_state_tracker
   import pad_bias_pkg::*;
#(
   parameter bit IS_REFERENCE = 1'b0
)
(
   input wire logic core_clk,
   input wire logic clear,
   input wire pad_bias_pkg::power_mode_t mode,
   input wire logic keep_full_load,
   output pad_bias_pkg::supply_state_t state
);
   import pad_bias_pkg::*;

   supply_state_t state_r;
   supply_state_t state_nxt;

   // Reference turns off with the device; regulator never turns off
   always_comb begin
      state_nxt = ST_SLEEP;
      case (mode)
         MODE_ACTIVE: state_nxt = ST_ACTIVE;
         MODE_SLEEP: state_nxt = ST_SLEEP;
         MODE_OFF: begin
            if (IS_REFERENCE) begin
               state_nxt = ST_OFF;
            end else if (keep_full_load) begin
               state_nxt = ST_ACTIVE;
            end else begin
               state_nxt = ST_SLEEP;
            end
         end
         MODE_BACKUP: begin
            state_nxt = IS_REFERENCE ? ST_OFF : ST_SLEEP;
         end
         default: state_nxt = ST_SLEEP;
      endcase
   end

   // Only the mode, keep_full_load and clear move the field; the bus cannot write it
   always_ff @(posedge core_clk) begin
      if (clear) begin
         state_r <= supply_state_t'(`STATE_RESET);
      end else begin
         state_r <= state_nxt;
      end
   end

   assign state = state_r;

endmodule : supply_state_tracker
`default_nettype wire

// ===== verilog/pad_bias_and_reference_regs.sv
/*
 Pad bias, reference state and always-on regulator register bank on a
 classic Wishbone slave with 32-bit data; each register takes the low
 byte of one aligned word.
 Assumes power_mode and turnoff_rst come from the power controller on
 core_clk, so they need no synchroniser.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "pad_bias_cfg.svh"
module pad_bias_and_reference_regs
   import pad_bias_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic turnoff_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pad_bias_pkg::power_mode_t power_mode,
   output pad_bias_pkg::pad_bias_t pad_bias,
   output logic always_on_regulator_low_power,
   output logic reference_on
);
   import pad_bias_pkg::*;

   // Bus request gathered into one carrier
   wb_req_t req;
   logic take;
   logic commit;
   logic ack;

   // Register storage and tracked states
   logic [6:0] pad_bias_r;
   logic off_state_full_load_keep_r;
   supply_state_t ref_state;
   supply_state_t aon_state;

   // Decode, read path and registered bus data
   reg_sel_t req_sel;
   logic [7:0] rd_byte;
   logic [31:0] wb_dat_o_r;
   logic lane0_write;
   logic ref_clear;
   logic [7:0] pad_merged;

   // Map a byte address to the register it hits; unaligned byte
   // addresses inside a word still hit that word, lane 0 carries the byte
   function automatic reg_sel_t decode_sel(input logic [7:0] adr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (adr[7:2] == `PAD_BIAS_IDX) begin
         sel = SEL_PAD;
      end else if (adr[7:2] == `REF_STATE_IDX) begin
         sel = SEL_REF;
      end else if (adr[7:2] == `AON_REG_IDX) begin
         sel = SEL_AON;
      end
      return sel;
   endfunction : decode_sel

   // Merge written byte under a mask of writable bits; others keep
   function automatic logic [7:0] merge_byte(
      input logic [7:0] old_val,
      input logic [7:0] new_val,
      input logic [7:0] mask
   );
      return (old_val & ~mask) | (new_val & mask);
   endfunction : merge_byte

   assign req.cyc = wb_cyc_i;
   assign req.stb = wb_stb_i;
   assign req.we = wb_we_i;
   assign req.adr = wb_adr_i;
   assign req.sel = wb_sel_i;
   assign req.dat = wb_dat_i;

   // Handshake: take in idle, one ack cycle, one gap cycle
   wb_word_slave u_bus (
      .core_clk(core_clk),
      .rst(rst),
      .req(req),
      .take(take),
      .commit(commit),
      .ack(ack)
   );

   assign req_sel = decode_sel(req.adr);
   // Only lane 0 carries register data; upper lanes are dropped
   assign lane0_write = commit && req.sel[0];

   // Written byte merged under the writable mask; bit 7 never stored
   assign pad_merged = merge_byte({1'b0, pad_bias_r}, req.dat[7:0],
      `PB_WRITE_MASK);

   // Pad bias register, general reset domain
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pad_bias_r <= `PB_RESET;
      end else if (lane0_write && (req_sel == SEL_PAD)) begin
         pad_bias_r <= pad_merged[6:0];
      end
   end

   // Off-state mask bit, general reset domain
   always_ff @(posedge core_clk) begin
      if (rst) begin
         off_state_full_load_keep_r <= `AON_MASK_RESET;
      end else if (lane0_write && (req_sel == SEL_AON)) begin
         off_state_full_load_keep_r <= req.dat[`AON_MASK_BIT];
      end
   end

   // Reference sits in the turn-off domain: either reset clears it
   assign ref_clear = rst || turnoff_rst;

   // Reference state follows the mode; no write path exists
   supply_state_tracker #(
      .IS_REFERENCE(1'b1)
   ) u_ref_state (
      .core_clk(core_clk),
      .clear(ref_clear),
      .mode(power_mode),
      .keep_full_load(1'b0),
      .state(ref_state)
   );

   // Regulator state honours the mask only in the off state
   supply_state_tracker #(
      .IS_REFERENCE(1'b0)
   ) u_aon_state (
      .core_clk(core_clk),
      .clear(rst),
      .mode(power_mode),
      .keep_full_load(off_state_full_load_keep_r),
      .state(aon_state)
   );

   // Read mux; reserved bits and unmapped words read zero
   always_comb begin
      rd_byte = 8'h00;
      case (req_sel)
         SEL_PAD: rd_byte = {1'b0, pad_bias_r};
         SEL_REF: rd_byte = {6'h00, ref_state};
         SEL_AON: begin
            rd_byte = {4'h0, off_state_full_load_keep_r, 1'b0,
               aon_state};
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data captured when the request is taken, stands with ack
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_dat_o_r <= 32'h0000_0000;
      end else if (take) begin
         wb_dat_o_r <= {24'h00_0000, rd_byte};
      end
   end

   assign wb_dat_o = wb_dat_o_r;
   assign wb_ack_o = ack;

   // Pad enables straight from the register bits
   assign pad_bias.ctrl_bus_pullup_en =
      pad_bias_r[`PB_CTRL_BUS_BIT];
   assign pad_bias.scaling_bus_pullup_en =
      pad_bias_r[`PB_SCALING_BUS_BIT];
   assign pad_bias.power_request_pullup_en =
      pad_bias_r[`PB_POWER_REQ_BIT];
   assign pad_bias.sleep_pin_pulldown_en =
      pad_bias_r[`PB_SLEEP_BIT];
   assign pad_bias.hold_pin_pulldown_en =
      pad_bias_r[`PB_HOLD_BIT];
   assign pad_bias.cold_reset_pin_pulldown_en =
      pad_bias_r[`PB_COLD_RESET_BIT];
   assign pad_bias.second_reset_out_pulldown_en =
      pad_bias_r[`PB_SECOND_RESET_BIT];

   // Regulator mode follows its reported state, one cycle after mode
   assign always_on_regulator_low_power = (aon_state == ST_SLEEP);
   assign reference_on = (ref_state != ST_OFF);

endmodule : pad_bias_and_reference_regs
`default_nettype wire

// ===== test/bank_checker.sv
/*
 Port assertions for the pad bias register bank.
 Assumes a classic Wishbone master with one request at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module bank_checker
   import pad_bias_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic turnoff_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire pad_bias_pkg::power_mode_t power_mode,
   input wire pad_bias_pkg::pad_bias_t pad_bias,
   input wire logic always_on_regulator_low_power,
   input wire logic reference_on
);
   logic mask_r;
   logic wr_ok;
   logic rd_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Write and read land only at the edge where ack is seen
   assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
   assign rd_ok = wb_ack_o && !wb_we_i;
   // Shadow of the off-state mask, so off-mode checks need no hierarchy
   always_ff @(posedge core_clk) begin
      if (rst)
         mask_r <= 1'b0;
      else if (wr_ok && wb_adr_i == 8'h78)
         mask_r <= wb_dat_i[3];
   end
   sequence bus_take; $rose(wb_stb_i) && wb_cyc_i; endsequence
   sequence ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
   ack_timing_a: assert property (bus_take |=> ack_pulse)
      else $error("ack not one pulse after take");
   pad_reset_a: assert property ($fell(rst) |-> pad_bias == 7'h1F &&
      reference_on && !always_on_regulator_low_power)
      else $error("reset values wrong");
   pad_write_a: assert property (wr_ok && wb_adr_i == 8'h70 |=>
      pad_bias == $past(wb_dat_i[6:0])) else $error("pad write lost");
   pad_read_a: assert property (rd_ok && wb_adr_i == 8'h70 |->
      wb_dat_o == {25'h0, pad_bias}) else $error("pad read wrong");
   ref_read_a: assert property (rd_ok && wb_adr_i == 8'h74 |->
      wb_dat_o[31:2] == 30'h0 && wb_dat_o[1:0] != 2'b10)
      else $error("reference read wrong");
   aon_read_a: assert property (rd_ok && wb_adr_i == 8'h78 |->
      wb_dat_o[31:2] == {28'h0, mask_r, 1'b0} && wb_dat_o[0])
      else $error("regulator read wrong");
   ref_off_a: assert property (!turnoff_rst && power_mode[1] |=>
      !reference_on) else $error("reference on in off mode");
   ref_turnoff_a: assert property (turnoff_rst |=> reference_on)
      else $error("turn-off reset ignored");
   backup_low_a: assert property (power_mode == MODE_BACKUP |=>
      always_on_regulator_low_power) else $error("backup not low power");
   off_mask_a: assert property (power_mode == MODE_OFF && !wr_ok |=>
      always_on_regulator_low_power == !mask_r)
      else $error("off mode ignores mask");
endmodule : bank_checker
bind pad_bias_and_reference_regs bank_checker chk_i (.core_clk, .rst,
   .turnoff_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .power_mode, .pad_bias,
   .always_on_regulator_low_power, .reference_on);
`default_nettype wire

// ===== test/tb_top.sv
/*
 Self-checking bench for the pad bias register bank.
 Assumes the bank acks each request within a few cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import pad_bias_pkg::*;
   logic core_clk, rst, turnoff_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0] ex_ref, ex_aon;
   power_mode_t power_mode;
   pad_bias_t pad_bias;
   logic always_on_regulator_low_power, reference_on;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   pad_bias_and_reference_regs DUT (.core_clk, .rst, .turnoff_rst,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .power_mode, .pad_bias,
      .always_on_regulator_low_power, .reference_on);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic end_sim;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Hang guard; the tests need well under a thousand cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Called just after a rising edge; request held until ack is sampled
   // high at an edge, data taken there, then one idle cycle follows
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(rd, exp);
   endtask : rdchk
   initial begin
      {rst, turnoff_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      power_mode = MODE_ACTIVE;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdchk(8'h70, 32'h1F);
      rdchk(8'h74, 32'h01);
      rdchk(8'h78, 32'h01);
      $display("Test reset values done");
      bus(1'b1, 8'h70, 32'hFF, 4'hF);
      rdchk(8'h70, 32'h7F);
      bus(1'b1, 8'h70, 32'h60, 4'hF);
      chk({25'h0, pad_bias}, 32'h60);
      bus(1'b1, 8'h70, 32'h1F, 4'hE);
      bus(1'b1, 8'h70, 32'h50, 4'h1);
      rdchk(8'h70, 32'h50);
      $display("Test pad bias done");
      bus(1'b1, 8'h74, 32'hFF, 4'hF);
      rdchk(8'h74, 32'h01);
      bus(1'b1, 8'h00, 32'hFF, 4'hF);
      rdchk(8'h00, 32'h0);
      bus(1'b1, 8'h78, 32'hF6, 4'hF);
      rdchk(8'h78, 32'h01);
      $display("Test read-only places done");
      // Every power mode with the off-state mask clear, then set
      for (int m = 0; m < 8; m++) begin
         bus(1'b1, 8'h78, {28'h0, m[2], 3'h0}, 4'h1);
         power_mode <= power_mode_t'(m[1:0]);
         repeat (2) @(posedge core_clk);
         ex_ref = (m[1:0] == 0) ? 2'h1 : (m[1:0] == 1) ? 2'h3 : 2'h0;
         ex_aon = (m[1:0] == 0 || (m[1:0] == 2 && m[2])) ? 2'h1 : 2'h3;
         chk({30'h0, reference_on, always_on_regulator_low_power},
            {30'h0, ex_ref != 2'h0, ex_aon[1]});
         rdchk(8'h74, {30'h0, ex_ref});
         rdchk(8'h78, {28'h0, m[2], 1'b0, ex_aon});
      end
      $display("Test power modes done");
      power_mode <= MODE_SLEEP;
      turnoff_rst <= 1'b1;
      @(posedge core_clk);
      rdchk(8'h74, 32'h01);
      turnoff_rst <= 1'b0;
      rdchk(8'h70, 32'h50);
      rdchk(8'h78, 32'h0B);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdchk(8'h70, 32'h1F);
      $display("Test resets done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
